// ### hdl/cmo_output_points.sv
// Output point control for a counter module: pattern, status, flags
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module cmo_output_points #(
    parameter logic [7:0] OWN_ID = 8'h00  // Arbitrary default slot
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Compare output function state
    input  wire logic        compare_output_fn,
    input  wire logic        table_compare_output_fn,
    input  wire logic [3:0]  cmp_points,
    // Module presence and point feedback pins
    input  wire logic        module_present,
    input  wire logic [3:0]  point_sense,
    // Output points
    output logic      [3:0]  out_point_0_to_3,
    // Flags
    output logic             busy_flag,
    output logic             error_flag,
    output logic             irq
);
    logic                                block_enable_r;
    logic                                enable_d_r;
    logic                                apply_request_r;
    logic [cmo_pkg::WORD_W-1:0]          out_pattern_r;
    logic [cmo_pkg::SEL_W-1:0]           module_select_r;
    logic [cmo_pkg::WORD_W-1:0]          out_status_r;
    logic [cmo_pkg::FAULT_W-1:0]         fault_code_r;
    logic [cmo_pkg::POINTS-1:0]          host_points_r;
    logic                                cmp_d_r;
    logic                                cmp_active;
    logic [1:0]                          cmp_sync;
    logic                                present_sync;
    logic [cmo_pkg::POINTS-1:0]          sense_sync;
    logic [cmo_pkg::POINTS-1:0]          cmp_pts_sync;
    logic                                rise;
    logic                                fall;
    logic                                sel_ok;
    logic                                wr_ctrl;
    logic                                ctrl_apply;
    logic [cmo_pkg::IRQ_N-1:0]           events;
    logic [cmo_pkg::IRQ_N-1:0]           irq_stat;
    logic [cmo_pkg::IRQ_N-1:0]           irq_mask;
    logic                                wr_pattern;
    logic                                wr_select;
    logic                                wr_mask;
    logic                                wr_clr;
    logic [cmo_pkg::FAULT_W-1:0]         fault_now;
    logic                                fault_hit;
    logic [31:0]                         rd_word;

    // Pin-side inputs come from another domain
    // Both compare flags cross apart; merged only after the flops
    cmo_sync #(.W(2)) u_sync_cmp (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d_in    ({compare_output_fn, table_compare_output_fn}),
        .d_out   (cmp_sync)
    );
    cmo_sync #(.W(1)) u_sync_present (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d_in    (module_present),
        .d_out   (present_sync)
    );
    cmo_sync #(.W(cmo_pkg::POINTS)) u_sync_sense (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d_in    (point_sense),
        .d_out   (sense_sync)
    );
    cmo_sync #(.W(cmo_pkg::POINTS)) u_sync_cmp_pts (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d_in    (cmp_points),
        .d_out   (cmp_pts_sync)
    );

    function automatic logic [31:0] zext16(input logic [15:0] v);
        zext16 = {16'h0000, v};
    endfunction

    // Start-up checks in priority order; first failure names the fault
    function automatic logic [cmo_pkg::FAULT_W-1:0] fault_of(
        input logic [cmo_pkg::SEL_W-1:0]  sel,
        input logic [cmo_pkg::WORD_W-1:0] pattern,
        input logic                       present,
        input logic                       own
    );
        if (sel > cmo_pkg::MODULE_MAX) begin
            fault_of = cmo_pkg::FAULT_BAD_SEL;
        end else if (pattern[15:4] != 12'h000) begin
            fault_of = cmo_pkg::FAULT_BAD_VALUE;
        end else if (!present || !own) begin
            fault_of = cmo_pkg::FAULT_NO_MODULE;
        end else begin
            fault_of = cmo_pkg::FAULT_NONE;
        end
    endfunction

    assign cmp_active = |cmp_sync;
    assign wr_ctrl    = reg_wr && (reg_addr == cmo_pkg::REG_CTRL);
    assign wr_pattern = reg_wr && (reg_addr == cmo_pkg::REG_PATTERN);
    assign wr_select  = reg_wr && (reg_addr == cmo_pkg::REG_SELECT);
    assign wr_mask    = reg_wr && (reg_addr == cmo_pkg::REG_IRQ_MASK);
    assign wr_clr     = reg_wr && (reg_addr == cmo_pkg::REG_IRQ_STAT);
    assign ctrl_apply = reg_wdata[cmo_pkg::CTRL_APPLY];
    assign rise       = block_enable_r && !enable_d_r;
    assign fall       = !block_enable_r && enable_d_r;
    assign sel_ok     = (module_select_r == OWN_ID)
                        && (module_select_r <= cmo_pkg::MODULE_MAX);
    assign fault_now  = fault_of(module_select_r, out_pattern_r,
                                 present_sync, sel_ok);
    assign fault_hit  = (fault_now != cmo_pkg::FAULT_NONE);

    // Enable bit is software-owned
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            block_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            block_enable_r <= reg_wdata[cmo_pkg::CTRL_ENABLE];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enable_d_r <= 1'b0;
            cmp_d_r    <= 1'b0;
        end else begin
            enable_d_r <= block_enable_r;
            cmp_d_r    <= cmp_active;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_pattern_r <= 16'h0000;
        end else if (wr_pattern) begin
            out_pattern_r <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            module_select_r <= 8'h00;
        end else if (wr_select) begin
            module_select_r <= reg_wdata[7:0];
        end
    end

    // Apply request: set by host, cleared by device the next cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            apply_request_r <= 1'b0;
        end else if (!block_enable_r) begin
            apply_request_r <= 1'b0;
        end else if (wr_ctrl && ctrl_apply) begin
            apply_request_r <= 1'b1;
        end else if (apply_request_r) begin
            apply_request_r <= 1'b0;
        end
    end

    // Host-requested point state; held while compare owns the points
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            host_points_r <= cmo_pkg::PATTERN_RST;
        end else if (rise && sel_ok && !cmp_active) begin
            host_points_r <= out_pattern_r[3:0];
        end else if (apply_request_r && sel_ok && !cmp_active) begin
            host_points_r <= out_pattern_r[3:0];
        end else if (cmp_d_r && !cmp_active && block_enable_r
                     && sel_ok) begin
            host_points_r <= out_pattern_r[3:0];
        end
    end

    // Compare function overrides the host pattern while it runs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_point_0_to_3 <= cmo_pkg::PATTERN_RST;
        end else if (cmp_active) begin
            out_point_0_to_3 <= cmp_pts_sync;
        end else begin
            out_point_0_to_3 <= host_points_r;
        end
    end

    // Status reflects sensed point levels, zero when disabled
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_status_r <= cmo_pkg::STATUS_RST;
        end else if (block_enable_r) begin
            out_status_r <= {12'h000, sense_sync};
        end else begin
            out_status_r <= cmo_pkg::STATUS_RST;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy_flag <= 1'b0;
        end else begin
            busy_flag <= block_enable_r;
        end
    end

    // Start-up checks: selected slot valid, pattern in range and module answering
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            error_flag   <= 1'b0;
            fault_code_r <= cmo_pkg::FAULT_NONE;
        end else if (!block_enable_r) begin
            error_flag   <= 1'b0;
            fault_code_r <= cmo_pkg::FAULT_NONE;
        end else if (rise && fault_hit) begin
            error_flag   <= 1'b1;
            fault_code_r <= fault_now;
        end
    end

    assign events[cmo_pkg::EV_STARTED]  = rise;
    assign events[cmo_pkg::EV_APPLIED]  = apply_request_r && sel_ok
                                          && !cmp_active;
    assign events[cmo_pkg::EV_FAULT]    = rise && fault_hit;
    assign events[cmo_pkg::EV_CMP_DONE] = cmp_d_r && !cmp_active;

    cmo_irq #(.N(cmo_pkg::IRQ_N)) u_irq (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .event_in (events),
        .mask_we  (wr_mask),
        .clr_we   (wr_clr),
        .wdata    (reg_wdata[cmo_pkg::IRQ_N-1:0]),
        .stat_r   (irq_stat),
        .mask_r   (irq_mask),
        .irq      (irq)
    );

    // Read mux stays combinational; only the returned word is registered
    always_comb begin
        case (reg_addr)
            cmo_pkg::REG_CTRL: begin
                rd_word = {27'h0, cmp_active, error_flag, busy_flag,
                           apply_request_r, block_enable_r};
            end
            cmo_pkg::REG_PATTERN:  rd_word = zext16(out_pattern_r);
            cmo_pkg::REG_SELECT:   rd_word = {24'h0, module_select_r};
            cmo_pkg::REG_STATUS:   rd_word = zext16(out_status_r);
            cmo_pkg::REG_FAULT:    rd_word = {24'h0, fault_code_r};
            cmo_pkg::REG_IRQ_STAT: rd_word = {28'h0, irq_stat};
            cmo_pkg::REG_IRQ_MASK: rd_word = {28'h0, irq_mask};
            cmo_pkg::REG_OWN_ID:   rd_word = {24'h0, OWN_ID};
            default:               rd_word = 32'h0000_0000;
        endcase
    end

    // Read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_word;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // cmo_output_points

// ### hdl/cmo_pkg.sv
// Constants shared by the counter module output point block
package cmo_pkg;
    localparam int          POINTS          = 4;
    localparam int          WORD_W          = 16;
    localparam int          SEL_W           = 8;
    localparam int          FAULT_W         = 8;
    localparam logic [7:0]  MODULE_MAX      = 8'h1f;
    localparam logic [3:0]  PATTERN_RST     = 4'h0;
    localparam logic [15:0] STATUS_RST      = 16'h0000;
    // Fault codes
    localparam logic [7:0]  FAULT_NONE      = 8'h00;
    localparam logic [7:0]  FAULT_BAD_SEL   = 8'h01;
    localparam logic [7:0]  FAULT_BAD_VALUE = 8'h02;
    localparam logic [7:0]  FAULT_NO_MODULE = 8'h03;
    // Register indices
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_PATTERN     = 4'h1;
    localparam logic [3:0]  REG_SELECT      = 4'h2;
    localparam logic [3:0]  REG_STATUS      = 4'h3;
    localparam logic [3:0]  REG_FAULT       = 4'h4;
    localparam logic [3:0]  REG_IRQ_STAT    = 4'h5;
    localparam logic [3:0]  REG_IRQ_MASK    = 4'h6;
    localparam logic [3:0]  REG_OWN_ID      = 4'h7;
    // Control register bits
    localparam int          CTRL_ENABLE     = 0;
    localparam int          CTRL_APPLY      = 1;
    localparam int          CTRL_BUSY       = 2;
    localparam int          CTRL_ERROR      = 3;
    localparam int          CTRL_CMP        = 4;
    // Interrupt event bits
    localparam int          IRQ_N           = 4;
    localparam int          EV_STARTED      = 0;
    localparam int          EV_APPLIED      = 1;
    localparam int          EV_FAULT        = 2;
    localparam int          EV_CMP_DONE     = 3;
endpackage

// ### hdl/cmo_sync.sv
// Two-flop synchroniser for external levels
`timescale 1ns/1ps
module cmo_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            d_out  <= '0;
        end else begin
            meta_r <= d_in;
            d_out  <= meta_r;
        end
    end
endmodule // cmo_sync

// ### hdl/cmo_irq.sv
// Sticky interrupt status with mask and write-one-to-clear
`timescale 1ns/1ps
module cmo_irq #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    // Events and software access
    input  wire logic [N-1:0] event_in,
    input  wire logic         mask_we,
    input  wire logic         clr_we,
    input  wire logic [N-1:0] wdata,
    // State
    output logic      [N-1:0] stat_r,
    output logic      [N-1:0] mask_r,
    output logic              irq
);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stat_r <= '0;
        end else begin
            // Set wins over a clear in the same cycle
            stat_r <= (stat_r & ~(clr_we ? wdata : '0)) | event_in;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mask_r <= '0;
        end else if (mask_we) begin
            mask_r <= wdata;
        end
    end

    assign irq = |(stat_r & mask_r);
endmodule // cmo_irq

// ### verification/cmo_output_points_chk.sv
// Port-level assertions for the output point block
`timescale 1ns/1ps
module cmo_output_points_chk #(
    parameter logic [7:0] OWN_ID = 8'h00
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        nrst,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Compare and feedback
    input wire logic        compare_output_fn,
    input wire logic        table_compare_output_fn,
    input wire logic [3:0]  cmp_points,
    input wire logic        module_present,
    input wire logic [3:0]  point_sense,
    // Outputs
    input wire logic [3:0]  out_point_0_to_3,
    input wire logic        busy_flag,
    input wire logic        error_flag,
    input wire logic        irq
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_busy_rise: assert property (
        reg_wr && reg_addr == cmo_pkg::REG_CTRL && reg_wdata[0]
        |-> ##[1:3] busy_flag) else $error("busy missed enable");
    a_busy_fall: assert property (
        reg_wr && reg_addr == cmo_pkg::REG_CTRL && !reg_wdata[0]
        |-> ##[1:3] !busy_flag) else $error("busy stuck high");
    a_error_clear: assert property (
        $fell(busy_flag) |-> ##[0:2] !error_flag)
        else $error("error kept after disable");
    a_status_idle: assert property (
        reg_rd && reg_addr == cmo_pkg::REG_STATUS && !busy_flag
        && !$past(busy_flag) |=> reg_rdata == 32'h0)
        else $error("status nonzero while disabled");
    a_status_width: assert property (
        reg_rd && reg_addr == cmo_pkg::REG_STATUS
        |=> reg_rdata[31:4] == 28'h0) else $error("status high bits set");
    a_own_id: assert property (
        reg_rd && reg_addr == cmo_pkg::REG_OWN_ID
        |=> reg_rdata == {24'h0, OWN_ID}) else $error("slot id wrong");
    a_points_hold: assert property (
        !busy_flag |-> $stable(out_point_0_to_3))
        else $error("points moved while disabled");
    // Sync latency of the compare path is covered by five cycles
    a_compare_wins: assert property (
        (compare_output_fn && busy_flag && $stable(cmp_points))[*5]
        |-> out_point_0_to_3 == cmp_points)
        else $error("pattern beat compare");
    a_table_wins: assert property (
        (table_compare_output_fn && busy_flag && $stable(cmp_points))[*5]
        |-> out_point_0_to_3 == cmp_points)
        else $error("pattern beat table compare");
    c_compare: cover property (compare_output_fn && busy_flag);
    c_table: cover property (table_compare_output_fn && busy_flag);
    c_error: cover property ($rose(error_flag));
    c_irq: cover property ($rose(irq));
endmodule // cmo_output_points_chk

// ### verification/cmo_far_end.sv
// Far-end model: compare function source and point feedback
`timescale 1ns/1ps
module cmo_far_end (
    // Host controls
    input  wire logic       busy_flag,
    input  wire logic       cmp_go,
    input  wire logic       tbl_go,
    input  wire logic [3:0] cmp_want,
    input  wire logic [3:0] flip,
    input  wire logic       present_in,
    // Point side
    input  wire logic [3:0] out_point_0_to_3,
    // To the block
    output logic            compare_output_fn,
    output logic            table_compare_output_fn,
    output logic [3:0]      cmp_points,
    output logic [3:0]      point_sense,
    output logic            module_present
);
    // Compare starts only once the block runs, so initial state is set
    assign compare_output_fn       = cmp_go & busy_flag;
    assign table_compare_output_fn = tbl_go & busy_flag;
    assign cmp_points              = cmp_want;
    // A shorted or open load shows as a flipped sense bit
    assign point_sense             = out_point_0_to_3 ^ flip;
    assign module_present          = present_in;
endmodule // cmo_far_end

// ### verification/test_counter_module_output_point_control.sv
// Self-checking bench for the output point block
`timescale 1ns/1ps
module test_counter_module_output_point_control;
    logic        ref_clk, nrst, reg_wr, reg_rd, busy_flag, error_flag, irq;
    logic [3:0]  reg_addr, points, cmp_want, flip;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic        cmp_go, tbl_go, present_in, cfn, tfn, mpres;
    logic [3:0]  cpts, sense;
    int          failures, checks;
    cmo_output_points DUT (.ref_clk(ref_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_output_fn(cfn),
        .table_compare_output_fn(tfn), .cmp_points(cpts),
        .module_present(mpres), .point_sense(sense),
        .out_point_0_to_3(points), .busy_flag(busy_flag),
        .error_flag(error_flag), .irq(irq));
    cmo_far_end FE (.busy_flag(busy_flag), .cmp_go(cmp_go), .tbl_go(tbl_go),
        .cmp_want(cmp_want), .flip(flip), .present_in(present_in),
        .out_point_0_to_3(points), .compare_output_fn(cfn),
        .table_compare_output_fn(tfn), .cmp_points(cpts),
        .point_sense(sense), .module_present(mpres));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task test_done;
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task chk_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        chk($sformatf("reg%0d", a), e, d);
    endtask
    task wait_busy(input logic v);
        int n;
        n = 0;
        while (busy_flag !== v && n < 20) begin
            cyc(1);
            n++;
        end
        if (busy_flag !== v) begin
            failures++;
            $display("BAD busy expected %b seen %b", v, busy_flag);
            test_done();
        end
    endtask
    task en(input logic [31:0] p);
        wr(cmo_pkg::REG_PATTERN, p);
        wr(cmo_pkg::REG_CTRL, 32'h1);
        wait_busy(1'b1);
        cyc(4);
    endtask
    task dis;
        wr(cmo_pkg::REG_CTRL, 32'h0);
        wait_busy(1'b0);
        cyc(2);
    endtask
    task t_reset;
        chk("points", 32'h0, 32'(points));
        chk("busy", 32'h0, 32'(busy_flag));
        chk_reg(cmo_pkg::REG_CTRL, 32'h0);
        chk_reg(cmo_pkg::REG_PATTERN, 32'h0);
        chk_reg(cmo_pkg::REG_STATUS, 32'h0);
        chk_reg(cmo_pkg::REG_OWN_ID, 32'h0);
        chk_reg(4'h9, 32'h0);
    endtask
    task t_start;
        wr(cmo_pkg::REG_SELECT, 32'h0);
        en(32'h5);
        chk("points", 32'h5, 32'(points));
        chk("err", 32'h0, 32'(error_flag));
        chk_reg(cmo_pkg::REG_STATUS, 32'h5);
        wr(cmo_pkg::REG_PATTERN, 32'ha);
        cyc(4);
        chk("points", 32'h5, 32'(points));
    endtask
    task t_apply;
        wr(cmo_pkg::REG_CTRL, 32'h3);
        cyc(4);
        chk("points", 32'ha, 32'(points));
        chk_reg(cmo_pkg::REG_CTRL, 32'h5);
        @(posedge ref_clk) flip <= 4'h1;
        cyc(6);
        chk_reg(cmo_pkg::REG_STATUS, 32'hb);
        @(posedge ref_clk) flip <= 4'h0;
    endtask
    task t_compare;
        @(posedge ref_clk) cmp_want <= 4'h3;
        cmp_go <= 1'b1;
        cyc(6);
        wr(cmo_pkg::REG_PATTERN, 32'hc);
        wr(cmo_pkg::REG_CTRL, 32'h3);
        cyc(4);
        chk("points", 32'h3, 32'(points));
        chk_reg(cmo_pkg::REG_STATUS, 32'h3);
        @(posedge ref_clk) cmp_go <= 1'b0;
        cyc(6);
        chk("points", 32'hc, 32'(points));
        @(posedge ref_clk) tbl_go <= 1'b1;
        cyc(6);
        chk("points", 32'h3, 32'(points));
        @(posedge ref_clk) tbl_go <= 1'b0;
        cyc(6);
        chk("points", 32'hc, 32'(points));
    endtask
    task t_stop;
        dis();
        chk_reg(cmo_pkg::REG_STATUS, 32'h0);
        wr(cmo_pkg::REG_PATTERN, 32'h1);
        wr(cmo_pkg::REG_CTRL, 32'h2);
        cyc(4);
        chk("points", 32'hc, 32'(points));
    endtask
    task automatic t_faults;
        logic [7:0]  sel [4] = '{8'h20, 8'h01, 8'h00, 8'h00};
        logic [31:0] pat [4] = '{32'h1, 32'h1, 32'h10, 32'h1};
        logic [7:0]  code [4] = '{cmo_pkg::FAULT_BAD_SEL,
            cmo_pkg::FAULT_NO_MODULE, cmo_pkg::FAULT_BAD_VALUE,
            cmo_pkg::FAULT_NO_MODULE};
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) present_in <= (i != 3);
            wr(cmo_pkg::REG_SELECT, {24'h0, sel[i]});
            en(pat[i]);
            chk("err", 32'h1, 32'(error_flag));
            chk_reg(cmo_pkg::REG_FAULT, {24'h0, code[i]});
            dis();
            chk("err", 32'h0, 32'(error_flag));
            chk_reg(cmo_pkg::REG_FAULT, 32'h0);
        end
        @(posedge ref_clk) present_in <= 1'b1;
        wr(cmo_pkg::REG_SELECT, 32'h0);
    endtask
    task t_irq;
        wr(cmo_pkg::REG_IRQ_MASK, 32'h0);
        wr(cmo_pkg::REG_IRQ_STAT, 32'hf);
        en(32'h6);
        chk_reg(cmo_pkg::REG_IRQ_STAT, 32'h1);
        chk("irq", 32'h0, 32'(irq));
        wr(cmo_pkg::REG_IRQ_MASK, 32'h1);
        cyc(1);
        chk("irq", 32'h1, 32'(irq));
        wr(cmo_pkg::REG_IRQ_STAT, 32'h1);
        cyc(1);
        chk("irq", 32'h0, 32'(irq));
        wr(cmo_pkg::REG_CTRL, 32'h3);
        cyc(2);
        chk_reg(cmo_pkg::REG_IRQ_STAT, 32'h2);
        dis();
    endtask
    initial begin
        nrst = 1'b0;
        {reg_wr, reg_rd, cmp_go, tbl_go} = 4'h0;
        {reg_addr, cmp_want, flip} = 12'h000;
        reg_wdata = 32'h0;
        present_in = 1'b1;
        failures = 0;
        checks = 0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        cyc(1);
        t_reset();
        t_start();
        t_apply();
        t_compare();
        t_stop();
        t_faults();
        t_irq();
        test_done();
    end
endmodule // test_counter_module_output_point_control
bind cmo_output_points cmo_output_points_chk #(.OWN_ID(OWN_ID)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .compare_output_fn(compare_output_fn),
    .table_compare_output_fn(table_compare_output_fn),
    .cmp_points(cmp_points), .module_present(module_present),
    .point_sense(point_sense), .out_point_0_to_3(out_point_0_to_3),
    .busy_flag(busy_flag), .error_flag(error_flag), .irq(irq));
